// File: rtl/power_module_supervisor.sv
// Supervisor: power-good, fault handling, sharing, sync, levels, ramp
// Function
// - Power-good off during ramp and faults
// - Power-good on/off at programmable thresholds
// - Polarity 00 active low, 01 high
// - Push-pull default, open-drain when selected
// - Status flag good only when healthy
// - Interleave word: group, count, order
// - Interleave resets 0x0021; phase from order
// - One sync source, others receivers
// - Frequency 230 kHz default, 180-250 accepted
// - Over-temperature retries, resumes below warning
// - Temperature limits and responses programmable
// - Input voltage limits acted on within 100us
// - Output overvoltage limit default 30% above
// - Overvoltage shuts down, re-enables when clear
// - Overcurrent droop to 8V, then restart
// - Sharing trims output toward share line
// - Sharing idle during start-up ramp
// - Sharing trim limited to 100mV
// - Four current thresholds pick three levels
// - Level changes ramp at transition rate while running
// - Ramp factor from measured output capacitance
`timescale 1ns/10ps
`include "pms_cfg.svh"
module power_module_supervisor
  import pms_pkg::*;
#(
  parameter int unsigned VIN_CYC = `VIN_RESP_CYC
)(
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  input  wire logic        CE,
  input  wire logic        CMD_WR,
  input  wire logic        CMD_RD,
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic [2:0]  CMD_SEL,
  input  wire logic [15:0] CMD_WDATA,
  output      logic [15:0] CMD_RDATA,
  output      logic        CMD_ACK,
  input  wire logic        ON_REQ,
  input  wire logic [15:0] VOUT_MV,
  input  wire logic [15:0] IOUT_CA,
  input  wire logic [15:0] TEMP_C,
  input  wire logic [15:0] VIN_MV,
  input  wire logic [15:0] SHARE_CA,
  input  wire logic [15:0] CAP_UF,
  input  wire logic        MEAS_TICK,
  input  wire logic        CAP_VALID,
  input  wire logic        GOOD_OR_SYNC_PIN_I,
  output      logic        GOOD_OR_SYNC_PIN_O,
  output      logic        GOOD_OR_SYNC_PIN_OE,
  input  wire logic        ADDR1_I,
  output      logic        ADDR1_O,
  output      logic        ADDR1_OE,
  output      logic        PWR_EN,
  output      logic [15:0] VOUT_REF_MV,
  output      logic [7:0]  TRIM_MV,
  output      logic [15:0] RAMP_TIME_US,
  output      logic [8:0]  PHASE_DEG,
  output      logic [7:0]  FSW_KHZ,
  output      logic        SW_CLK
);

  localparam logic [15:0] RST_VAL [32] = '{
    `R_VOUT, `R_RATE, `R_FREQ, `R_IL, `R_OVP, `R_OCF, `R_OCLV, `R_OTF,
    `R_OTW, `R_UTF, `R_VINOV, `R_VINUV, `R_PGON, `R_PGOFF, `R_RISE,
    `R_POL, `R_RESP, `R_PINS,
    `R_THR, `R_THR2, `R_THR3, `R_THR4, `R_VOUT, `R_VOUT, `R_OFF,
    `R_K1, `R_K2, `R_K3, `R_L1, `R_L2, `R_L3, `R_OFF};
  localparam logic [4:0] ART_BASE = 5'(RI_DBV) + 5'(`BLK_LEN);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Command code to register index; bit 5 marks a hit
  function automatic logic [5:0] map_code(input logic [7:0] c,
                                          input logic [2:0] s);
    map_code = 6'h00;
    case (c)
      `C_VOUT:  map_code = {1'b1, RI_VOUT};
      `C_RATE:  map_code = {1'b1, RI_RATE};
      `C_FREQ:  map_code = {1'b1, RI_FREQ};
      `C_IL:    map_code = {1'b1, RI_IL};
      `C_OVP:   map_code = {1'b1, RI_OVP};
      `C_OCF:   map_code = {1'b1, RI_OCF};
      `C_OCLV:  map_code = {1'b1, RI_OCLV};
      `C_OTF:   map_code = {1'b1, RI_OTF};
      `C_OTW:   map_code = {1'b1, RI_OTW};
      `C_UTF:   map_code = {1'b1, RI_UTF};
      `C_VINOV: map_code = {1'b1, RI_VINOV};
      `C_VINUV: map_code = {1'b1, RI_VINUV};
      `C_PGON:  map_code = {1'b1, RI_PGON};
      `C_PGOFF: map_code = {1'b1, RI_PGOFF};
      `C_RISE:  map_code = {1'b1, RI_RISE};
      `C_POL:   map_code = {1'b1, RI_POL};
      `C_RESP:  map_code = {1'b1, RI_RESP};
      `C_PINS:  map_code = {1'b1, RI_PINS};
      `C_DBV:   if (s < `BLK_LEN) map_code = {1'b1, 5'(RI_DBV) + {2'h0, s}};
      `C_ART:   if (s < `BLK_LEN) map_code = {1'b1, ART_BASE + {2'h0, s}};
      default:  map_code = 6'h00;
    endcase
  endfunction

  // Output within about 6 % of its reference
  function automatic logic in_tol(input logic [15:0] v,
                                  input logic [15:0] r);
    logic [15:0] d;
    d = (v > r) ? v - r : r - v;
    in_tol = d <= (r >> 4);
  endfunction

  // Phase offset in degrees for an interleave word
  function automatic logic [8:0] phase_of(input logic [15:0] il);
    logic [12:0] num;
    num = 13'd360 * {9'h000, il[3:0]};
    phase_of = (il[7:4] == 4'h0) ? 9'h000 :
               9'(num / {9'h000, il[7:4]});
  endfunction

  // ****************************************************************
  // Command port and register file
  // ****************************************************************
  logic [15:0] regs_r [32];
  logic [15:0] regs_nxt [32];
  logic [15:0] rdata_r, rdata_nxt, stat_w, pins, mask;
  logic        ack_r, ack_nxt;
  logic [5:0]  hit;

  // Writes to the frequency outside the range are dropped so the
  // divider below never sees a value it cannot meet
  always_comb begin
    regs_nxt  = regs_r;
    rdata_nxt = rdata_r;
    ack_nxt   = 1'b0;
    hit       = map_code(CMD_CODE, CMD_SEL);
    case (hit[4:0])
      RI_POL, RI_PINS: mask = 16'h00FF;
      RI_IL:           mask = 16'h0FFF;
      default:         mask = 16'hFFFF;
    endcase
    if (CMD_WR && hit[5]) begin
      ack_nxt = !(hit[4:0] == RI_FREQ &&
                  (CMD_WDATA < `FSW_MIN || CMD_WDATA > `FSW_MAX));
      if (ack_nxt) begin
        regs_nxt[hit[4:0]] = CMD_WDATA & mask;
      end
    end
    if (CMD_RD) begin
      ack_nxt   = hit[5] || CMD_CODE == `C_STAT;
      rdata_nxt = (CMD_CODE == `C_STAT) ? stat_w :
                  hit[5] ? regs_r[hit[4:0]] : 16'h0000;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      regs_r  <= RST_VAL;
      rdata_r <= 16'h0000;
      ack_r   <= 1'b0;
    end else if (CE) begin
      regs_r  <= regs_nxt;
      rdata_r <= rdata_nxt;
      ack_r   <= ack_nxt;
    end
  end

  assign pins      = regs_r[RI_PINS];
  assign CMD_RDATA = rdata_r;
  assign CMD_ACK   = ack_r;
  assign FSW_KHZ   = regs_r[RI_FREQ][7:0];

  // ****************************************************************
  // Supervision datapath
  // ****************************************************************
  state_t      st_r, st_nxt;
  level_t      lvl_r, lvl_nxt;
  logic [9:0]  rc_r, rc_nxt;
  logic [14:0] vc_r, vc_nxt;
  logic [15:0] ref_r, ref_nxt, rt_r, rt_nxt, tgt, stp;
  logic [15:0] kf;
  logic [11:0] swc_r, swc_nxt, per;
  logic [8:0]  ph_r, ph_nxt;
  logic signed [7:0] trim_r, trim_nxt;
  logic vinf_r, vinf_nxt, ot_r, ot_nxt, pg_r, pg_nxt, en_r, en_nxt;
  logic sy_r, sy_nxt, swk_r, swk_nxt, po_r, po_nxt, poe_r, poe_nxt;
  logic ao_r, ao_nxt, aoe_r, aoe_nxt, lvl_pin;
  logic ut, output_overvolt_guard, overcurrent_guard, vin_bad, sd, any_flt, sync_in, is_src, is_rcv;

  // Fault conditions; a response bit set means continue running
  assign ut      = TEMP_C < regs_r[RI_UTF];
  assign output_overvolt_guard     = VOUT_MV > regs_r[RI_OVP];
  assign overcurrent_guard     = IOUT_CA > regs_r[RI_OCF] &&
                   VOUT_MV < regs_r[RI_OCLV];
  assign vin_bad = VIN_MV > regs_r[RI_VINOV] || VIN_MV < regs_r[RI_VINUV];
  assign any_flt = ot_r || ut || vinf_r || output_overvolt_guard || overcurrent_guard;
  assign sd = ((ot_r || ut) && !regs_r[RI_RESP][`F_TEMP]) ||
              (vinf_r && !regs_r[RI_RESP][`F_VIN]) ||
              (output_overvolt_guard && !regs_r[RI_RESP][`F_OVP]) || overcurrent_guard;
  assign is_src  = pins[`P_SOUT];
  assign is_rcv  = pins[`P_SIN] && !pins[`P_SOUT];
  assign sync_in = pins[`P_SA1] ? ADDR1_I : GOOD_OR_SYNC_PIN_I;
  assign per     = 12'(32'(`CLK_KHZ) / {16'h0000, regs_r[RI_FREQ]});
  assign stat_w  = {4'h0, pg_r && in_tol(VOUT_MV, ref_r), 4'h0,
                    st_r != ST_RUN, output_overvolt_guard, overcurrent_guard, vinf_r, ot_r || ut,
                    2'h0};

  always_comb begin
    st_nxt   = st_r;
    rc_nxt   = rc_r;
    rt_nxt   = rt_r;
    lvl_nxt  = lvl_r;
    ref_nxt  = ref_r;
    trim_nxt = trim_r;
    // Over-temperature holds until below the warning limit
    ot_nxt = (TEMP_C > regs_r[RI_OTF]) ||
             (ot_r && TEMP_C >= regs_r[RI_OTW]);
    // Input fault is qualified for the response window
    vc_nxt   = vin_bad ? ((vc_r < 15'(VIN_CYC)) ? vc_r + 15'h0001 : vc_r)
                       : 15'h0000;
    vinf_nxt = vin_bad && vc_nxt >= 15'(VIN_CYC);
    kf = (CAP_UF < regs_r[ART_BASE + 5'h03]) ? regs_r[ART_BASE] :
         (CAP_UF < regs_r[ART_BASE + 5'h04]) ? regs_r[ART_BASE + 5'h01] :
         regs_r[ART_BASE + 5'h02];
    case (st_r)
      ST_OFF: begin
        rt_nxt = regs_r[RI_RISE];
        if (ON_REQ && !sd) st_nxt = ST_RAMP;
      end
      ST_RAMP: begin
        if (CAP_VALID && regs_r[ART_BASE + 5'(`BLK_EN)][0]) begin
          rt_nxt = 16'(regs_r[RI_RISE] * kf);
        end
        if (sd) st_nxt = ST_FAULT;
        else if (!ON_REQ) st_nxt = ST_OFF;
        else if (in_tol(VOUT_MV, ref_r)) st_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (sd) st_nxt = ST_FAULT;
        else if (!ON_REQ) st_nxt = ST_OFF;
      end
      ST_FAULT: begin
        // Hiccup: wait out the retry time with the fault gone
        rc_nxt = sd ? 10'h000 : rc_r + 10'h001;
        if (rc_r == 10'(`RETRY_CYC - 1)) st_nxt = ST_OFF;
      end
      default: st_nxt = ST_OFF;
    endcase
    if (st_nxt != ST_FAULT) rc_nxt = 10'h000;
    en_nxt = st_nxt == ST_RAMP || st_nxt == ST_RUN;
    // Load level selector, one step per measurement
    if (MEAS_TICK && regs_r[5'(RI_DBV) + 5'(`BLK_EN)][0]) begin
      case (lvl_r)
        LV_LOW: if (IOUT_CA > regs_r[RI_DBV]) lvl_nxt = LV_MID;
        LV_MID: begin
          if (IOUT_CA < regs_r[5'(RI_DBV) + 5'h01]) lvl_nxt = LV_LOW;
          else if (IOUT_CA > regs_r[5'(RI_DBV) + 5'h02]) lvl_nxt = LV_HIGH;
        end
        LV_HIGH: if (IOUT_CA < regs_r[5'(RI_DBV) + 5'h03]) lvl_nxt = LV_MID;
        default: lvl_nxt = LV_HIGH;
      endcase
    end else if (!regs_r[5'(RI_DBV) + 5'(`BLK_EN)][0]) begin
      lvl_nxt = LV_HIGH;
    end
    tgt = (lvl_r == LV_LOW) ? regs_r[5'(RI_DBV) + 5'h04] :
          (lvl_r == LV_MID) ? regs_r[5'(RI_DBV) + 5'h05] :
          regs_r[RI_VOUT];
    stp = (ref_r > tgt) ? ref_r - tgt : tgt - ref_r;
    if (stp > regs_r[RI_RATE]) stp = regs_r[RI_RATE];
    if (st_r != ST_RUN) ref_nxt = tgt;
    else if (MEAS_TICK) begin
      ref_nxt = (ref_r > tgt) ? ref_r - stp : ref_r + stp;
    end
    // Share trim steps 1 mV per measurement, clamped, idle in ramp
    if (st_r != ST_RUN || !pins[`P_ACS]) trim_nxt = 8'sh00;
    else if (MEAS_TICK) begin
      if (IOUT_CA < SHARE_CA && trim_r < $signed(`SHARE_MV))
        trim_nxt = trim_r + 8'sh01;
      else if (IOUT_CA > SHARE_CA && trim_r > -$signed(`SHARE_MV))
        trim_nxt = trim_r - 8'sh01;
    end
    // Power-good with hysteresis, forced off outside regulation
    if (st_r != ST_RUN || any_flt) pg_nxt = 1'b0;
    else if (pg_r) pg_nxt = VOUT_MV >= regs_r[RI_PGOFF];
    else pg_nxt = VOUT_MV > regs_r[RI_PGON];
    lvl_pin = regs_r[RI_POL][0] ? pg_nxt : !pg_nxt;
    // Switching clock; a receiver realigns on the sync edge
    sy_nxt  = sync_in;
    swc_nxt = ((is_rcv && sync_in && !sy_r) || swc_r >= per - 12'h001)
              ? 12'h000 : swc_r + 12'h001;
    swk_nxt = swc_nxt < (per >> 1);
    ph_nxt  = phase_of(regs_r[RI_IL]);
    // Pin 6 carries sync when chosen there, else power-good if enabled and not a receiver
    po_nxt  = 1'b0;
    poe_nxt = 1'b0;
    if (is_src && !pins[`P_SA1]) begin
      po_nxt  = swk_nxt;
      poe_nxt = 1'b1;
    end else if (!is_rcv && pins[`P_PG]) begin
      po_nxt  = pins[`P_OD] ? 1'b0 : lvl_pin;
      poe_nxt = pins[`P_OD] ? !lvl_pin : 1'b1;
    end
    ao_nxt  = swk_nxt;
    aoe_nxt = is_src && pins[`P_SA1];
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      st_r <= ST_OFF;
      lvl_r <= LV_HIGH;
      rc_r <= 10'h000;
      vc_r <= 15'h0000;
      rt_r <= `R_RISE;
      ref_r <= `R_VOUT;
      trim_r <= 8'sh00;
      swc_r <= 12'h000;
      ph_r <= 9'h000;
      {vinf_r, ot_r, pg_r, en_r, sy_r, swk_r} <= 6'h00;
      {ao_r, aoe_r, po_r, poe_r} <= 4'h0;
    end else if (CE) begin
      st_r <= st_nxt;
      lvl_r <= lvl_nxt;
      rc_r <= rc_nxt;
      vc_r <= vc_nxt;
      rt_r <= rt_nxt;
      ref_r <= ref_nxt;
      trim_r <= trim_nxt;
      swc_r <= swc_nxt;
      ph_r <= ph_nxt;
      {vinf_r, ot_r, pg_r, en_r} <= {vinf_nxt, ot_nxt, pg_nxt, en_nxt};
      {sy_r, swk_r} <= {sy_nxt, swk_nxt};
      {ao_r, aoe_r, po_r, poe_r} <= {ao_nxt, aoe_nxt, po_nxt, poe_nxt};
    end
  end

  assign PWR_EN       = en_r;
  assign VOUT_REF_MV  = ref_r;
  assign TRIM_MV      = trim_r;
  assign RAMP_TIME_US = rt_r;
  assign PHASE_DEG    = ph_r;
  assign SW_CLK       = swk_r;
  assign GOOD_OR_SYNC_PIN_O    = po_r;
  assign GOOD_OR_SYNC_PIN_OE   = poe_r;
  assign ADDR1_O      = ao_r;
  assign ADDR1_OE     = aoe_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_pg_off;
    @(posedge CLK_SYS) disable iff (!NRST)
    CE && (st_r != ST_RUN || any_flt) |=> !pg_r;
  endproperty
  a_pg_off: assert property (p_pg_off)
    else $error("power-good set outside healthy run");
  property p_pg_on;
    @(posedge CLK_SYS) disable iff (!NRST)
    CE && st_r == ST_RUN && !any_flt && VOUT_MV > regs_r[RI_PGON]
    |=> pg_r;
  endproperty
  a_pg_on: assert property (p_pg_on)
    else $error("power-good missed above on threshold");
  property p_pol;
    @(posedge CLK_SYS) disable iff (!NRST)
    CE && !is_src && !is_rcv && pins[`P_PG] && !pins[`P_OD]
    |=> GOOD_OR_SYNC_PIN_OE && GOOD_OR_SYNC_PIN_O == ($past(regs_r[RI_POL][0]) ~^ pg_r);
  endproperty
  a_pol: assert property (p_pol)
    else $error("power-good pin level wrong for polarity");
  property p_od;
    @(posedge CLK_SYS) disable iff (!NRST)
    CE && pins[`P_OD] && !is_src |=> !GOOD_OR_SYNC_PIN_O;
  endproperty
  a_od: assert property (p_od)
    else $error("open-drain pin driven high");
  property p_stat;
    @(posedge CLK_SYS) disable iff (!NRST)
    CE && CMD_RD && CMD_CODE == `C_STAT && !pg_r |=> !CMD_RDATA[`S_PG];
  endproperty
  a_stat: assert property (p_stat)
    else $error("status good flag without power-good");
  property p_phase;
    @(posedge CLK_SYS) disable iff (!NRST)
    CE ##1 CE |-> PHASE_DEG == phase_of($past(regs_r[RI_IL]));
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase offset does not follow interleave");
  property p_trim;
    @(posedge CLK_SYS) disable iff (!NRST)
    (trim_r <= 8'sh64 && trim_r >= -8'sh64) and
    (st_r != ST_RUN && CE |=> trim_r == 8'sh00);
  endproperty
  a_trim: assert property (p_trim)
    else $error("share trim out of range or active in ramp");
  property p_vin;
    @(posedge CLK_SYS) disable iff (!NRST)
    (vc_r <= 15'(VIN_CYC)) and (vinf_r |-> vc_r == 15'(VIN_CYC));
  endproperty
  a_vin: assert property (p_vin)
    else $error("input fault qualification wrong");
  property p_ovp;
    @(posedge CLK_SYS) disable iff (!NRST)
    CE && output_overvolt_guard && !regs_r[RI_RESP][`F_OVP] |=> !PWR_EN;
  endproperty
  a_ovp: assert property (p_ovp)
    else $error("output not shut down on overvoltage");
  property p_step;
    @(posedge CLK_SYS) disable iff (!NRST)
    lvl_r == LV_LOW |=> lvl_r != LV_HIGH;
  endproperty
  a_step: assert property (p_step)
    else $error("level moved two steps at once");
  c_pg: cover property (@(posedge CLK_SYS) disable iff (!NRST)
    !pg_r ##1 pg_r);
  c_flt: cover property (@(posedge CLK_SYS) disable iff (!NRST)
    st_r == ST_RUN ##1 st_r == ST_FAULT);
  c_low: cover property (@(posedge CLK_SYS) disable iff (!NRST)
    lvl_r == LV_MID ##1 lvl_r == LV_LOW);
endmodule

// File: rtl/pms_cfg.svh
// Command codes, field positions, reset values and timing of the supervisor
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH
`define C_VOUT   8'h21
`define C_RATE   8'h27
`define C_FREQ   8'h33
`define C_IL     8'h37
`define C_OVP    8'h40
`define C_OCF    8'h46
`define C_OCLV   8'h48
`define C_OTF    8'h4F
`define C_OTW    8'h51
`define C_UTF    8'h53
`define C_VINOV  8'h55
`define C_VINUV  8'h59
`define C_PGON   8'h5E
`define C_PGOFF  8'h5F
`define C_RISE   8'h61
`define C_STAT   8'h79
`define C_POL    8'hD0
`define C_RESP   8'hE1
`define C_DBV    8'hEF
`define C_ART    8'hF7
`define C_PINS   8'hF9
`define BLK_LEN  3'h7
`define BLK_EN   3'h6
// Reset values (mV, 10 mA, degC, kHz, us)
`define R_VOUT   16'h2EE0
`define R_RATE   16'h000A
`define R_FREQ   16'h00E6
`define R_IL     16'h0021
`define R_OVP    16'h3CF0
`define R_OCF    16'h1D4C
`define R_OCLV   16'h1F40
`define R_OTF    16'h007D
`define R_OTW    16'h0073
`define R_UTF    16'h0000
`define R_VINOV  16'hEA60
`define R_VINUV  16'h9C40
`define R_PGON   16'h1F40
`define R_PGOFF  16'h1388
`define R_RISE   16'h2710
`define R_POL    16'h0000
`define R_RESP   16'h0000
`define R_PINS   16'h0004
`define R_THR    16'h0FA0
`define R_THR2   16'h0BB8
`define R_THR3   16'h1770
`define R_THR4   16'h1388
`define R_K1     16'h0001
`define R_K2     16'h0002
`define R_K3     16'h0003
`define R_L1     16'h0100
`define R_L2     16'h0400
`define R_L3     16'h1000
`define R_OFF    16'h0000
// Field positions
`define P_ACS    0
`define P_OD     1
`define P_PG     2
`define P_SOUT   3
`define P_SIN    4
`define P_SA1    5
`define F_TEMP   0
`define F_VIN    1
`define F_OVP    2
`define S_OFF    6
`define S_OV     5
`define S_OC     4
`define S_VIN    3
`define S_TEMP   2
`define S_PG     11
`define FSW_MIN  16'h00B4
`define FSW_MAX  16'h00FA
`define SHARE_MV 8'h64
// Timing
`define CLK_MHZ      250
`define CLK_KHZ      250000
`define VIN_RESP_NS  100000
`define VIN_RESP_CYC ((`VIN_RESP_NS * `CLK_MHZ) / 1000)
`define RETRY_NS     4000
`define RETRY_CYC    ((`RETRY_NS * `CLK_MHZ) / 1000)
`endif

// File: rtl/pms_pkg.sv
// Types shared by the supervisor
package pms_pkg;
  typedef enum {ST_OFF, ST_RAMP, ST_RUN, ST_FAULT} state_t;
  typedef enum {LV_LOW, LV_MID, LV_HIGH} level_t;
  typedef enum logic [4:0] {
    RI_VOUT, RI_RATE, RI_FREQ, RI_IL, RI_OVP, RI_OCF, RI_OCLV, RI_OTF,
    RI_OTW, RI_UTF, RI_VINOV, RI_VINUV, RI_PGON, RI_PGOFF, RI_RISE,
    RI_POL, RI_RESP, RI_PINS, RI_DBV
  } reg_idx_t;
endpackage

// File: test/peer_module.sv
// Paralleled peer module on the shared pin, sync and share lines
`timescale 1ns/10ps
module peer_module #(
  parameter logic [15:0] SHARE = 16'h05DC
)(
  input  wire logic        clk,
  input  wire logic        pg_o,
  input  wire logic        pg_oe,
  input  wire logic        a1_o,
  input  wire logic        a1_oe,
  output      logic        pg_wire,
  output      logic        a1_wire,
  output      logic [15:0] share_ca
);
  // ********************************
  // Shared lines
  // ********************************
  logic [3:0] div_r = 4'h0;

  // Peer sources sync unless ours drives the line; its clock runs free
  always_ff @(posedge clk) begin
    div_r <= div_r + 4'h1;
  end

  // Pull-up holds the line high whenever nobody drives it
  assign pg_wire = pg_oe ? pg_o : 1'b1;
  // A driving sync-out unit wins over the peer
  assign a1_wire = a1_oe ? a1_o : div_r[3];
  // Peer's own current, higher than ours, so trim must rise
  assign share_ca = SHARE;
endmodule

// File: test/tb.sv
// Self-checking bench of the supervisor through its command port
`timescale 1ns/10ps
`include "pms_cfg.svh"
module tb
  import pms_pkg::*;
;
  // ********************************
  // Bench
  // ********************************
  logic        CLK_SYS, NRST, CE, CMD_WR, CMD_RD, ON_REQ, MEAS_TICK;
  logic        CAP_VALID, CMD_ACK, GOOD_OR_SYNC_PIN_O, GOOD_OR_SYNC_PIN_OE, PG_W, A1_W;
  logic        ADDR1_O, ADDR1_OE, PWR_EN, SW_CLK;
  logic [2:0]  CMD_SEL;
  logic [7:0]  CMD_CODE, TRIM_MV, FSW_KHZ;
  logic [8:0]  PHASE_DEG;
  logic [15:0] CMD_WDATA, VOUT_MV, IOUT_CA, TEMP_C, VIN_MV, CAP_UF;
  logic [15:0] SHARE_CA, CMD_RDATA, RAMP_TIME_US, REF_MV;
  logic [7:0]  fq [4] = '{8'hB3, 8'hB4, 8'hFA, 8'hFB};
  logic [15:0] fx [4] = '{16'h00E6, 16'h00B4, 16'h00FA, 16'h00FA};
  int          mismatches, comparisons;

  // 250 MHz clock
  always #2 CLK_SYS = ~CLK_SYS;

  power_module_supervisor #(.VIN_CYC(20)) u_dut (
    .CLK_SYS(CLK_SYS), .NRST(NRST), .CE(CE), .CMD_WR(CMD_WR),
    .CMD_RD(CMD_RD), .CMD_CODE(CMD_CODE), .CMD_SEL(CMD_SEL),
    .CMD_WDATA(CMD_WDATA), .CMD_RDATA(CMD_RDATA), .CMD_ACK(CMD_ACK),
    .ON_REQ(ON_REQ), .VOUT_MV(VOUT_MV), .IOUT_CA(IOUT_CA),
    .TEMP_C(TEMP_C), .VIN_MV(VIN_MV), .SHARE_CA(SHARE_CA),
    .CAP_UF(CAP_UF), .MEAS_TICK(MEAS_TICK), .CAP_VALID(CAP_VALID),
    .GOOD_OR_SYNC_PIN_I(PG_W), .GOOD_OR_SYNC_PIN_O(GOOD_OR_SYNC_PIN_O), .GOOD_OR_SYNC_PIN_OE(GOOD_OR_SYNC_PIN_OE),
    .ADDR1_I(A1_W), .ADDR1_O(ADDR1_O), .ADDR1_OE(ADDR1_OE),
    .PWR_EN(PWR_EN), .VOUT_REF_MV(REF_MV), .TRIM_MV(TRIM_MV),
    .RAMP_TIME_US(RAMP_TIME_US), .PHASE_DEG(PHASE_DEG),
    .FSW_KHZ(FSW_KHZ), .SW_CLK(SW_CLK)
  );

  peer_module u_peer (
    .clk(CLK_SYS), .pg_o(GOOD_OR_SYNC_PIN_O), .pg_oe(GOOD_OR_SYNC_PIN_OE), .a1_o(ADDR1_O),
    .a1_oe(ADDR1_OE), .pg_wire(PG_W), .a1_wire(A1_W), .share_ca(SHARE_CA)
  );

  // Compare and count
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task stop_test();
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Sample just after the edge so its updates have landed
  task settle(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask

  // One access: strobe for one cycle, answer in the next
  task acc(input logic w, input logic [7:0] c, input logic [2:0] s,
           input logic [15:0] d, input logic a, input logic [15:0] r);
    @(posedge CLK_SYS);
    CMD_WR <= w;
    CMD_RD <= !w;
    CMD_CODE <= c;
    CMD_SEL <= s;
    CMD_WDATA <= d;
    @(posedge CLK_SYS);
    CMD_WR <= 1'b0;
    CMD_RD <= 1'b0;
    #1;
    chk("ack", CMD_ACK, a);
    if (!w)
      chk("rdata", CMD_RDATA, r);
  endtask

  // Bounded wait; a hang ends the run
  task wait_en(input logic v, input int n);
    settle(1);
    for (int i = 0; i < n && PWR_EN !== v; i++)
      settle(1);
    chk("pwr_en", PWR_EN, v);
    if (PWR_EN !== v)
      stop_test();
  endtask

  task tick(input int n);
    repeat (n) begin
      @(posedge CLK_SYS);
      MEAS_TICK <= 1'b1;
      @(posedge CLK_SYS);
      MEAS_TICK <= 1'b0;
    end
    settle(1);
  endtask

  task cap(input logic [15:0] v);
    @(posedge CLK_SYS);
    CAP_UF <= v;
    CAP_VALID <= 1'b1;
    @(posedge CLK_SYS);
    CAP_VALID <= 1'b0;
    settle(3);
  endtask

  // Length of one low phase of the sync line, in system cycles
  task half_low(input logic [15:0] e);
    int n;
    n = 0;
    for (int i = 0; i < 1100 && A1_W !== 1'b1; i++)
      settle(1);
    for (int i = 0; i < 1100 && A1_W === 1'b1; i++)
      settle(1);
    for (int i = 0; i < 1100 && A1_W === 1'b0; i++) begin
      settle(1);
      n++;
    end
    chk("sync low", n[15:0], e);
  endtask

  task drive(input logic [15:0] vo, input logic [15:0] io,
             input logic [15:0] vi, input logic [15:0] t);
    @(posedge CLK_SYS);
    VOUT_MV <= vo;
    IOUT_CA <= io;
    VIN_MV <= vi;
    TEMP_C <= t;
  endtask

  // Main sequence; CE drops once to check the freeze
  initial begin
    {CLK_SYS, NRST, CMD_WR, CMD_RD, ON_REQ, MEAS_TICK, CAP_VALID} = 7'h00;
    {CMD_CODE, CMD_SEL, CMD_WDATA, CAP_UF} = 43'h0;
    CE = 1'b1;
    {VOUT_MV, IOUT_CA, VIN_MV, TEMP_C} = 64'h0000_03E8_BB80_0019;
    repeat (3) @(posedge CLK_SYS);
    NRST <= 1'b1;
    settle(2);
    chk("phase", PHASE_DEG, 9'h0B4);
    chk("fsw", FSW_KHZ, 8'hE6);
    acc(1'b0, `C_IL, 3'h0, 16'h0000, 1'b1, `R_IL);
    acc(1'b0, `C_POL, 3'h0, 16'h0000, 1'b1, `R_POL);
    acc(1'b0, 8'h22, 3'h0, 16'h0000, 1'b0, 16'h0000);
    acc(1'b1, `C_STAT, 3'h0, 16'hFFFF, 1'b0, 16'h0000);
    acc(1'b1, `C_DBV, 3'h7, 16'h0000, 1'b0, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, `C_FREQ, 3'h0, {8'h00, fq[i]}, i == 1 || i == 2, 16'h0);
      acc(1'b0, `C_FREQ, 3'h0, 16'h0000, 1'b1, fx[i]);
    end
    chk("fsw", FSW_KHZ, 8'hFA);
    acc(1'b1, `C_IL, 3'h0, 16'hFF31, 1'b1, 16'h0000);
    acc(1'b0, `C_IL, 3'h0, 16'h0000, 1'b1, 16'h0F31);
    settle(3);
    chk("phase", PHASE_DEG, 9'h078);
    acc(1'b1, `C_ART, 3'h6, 16'h0001, 1'b1, 16'h0000);
    acc(1'b1, `C_PGOFF, 3'h0, 16'h2CEC, 1'b1, 16'h0000);
    // On level kept above the off level so the flag cannot toggle
    acc(1'b1, `C_PGON, 3'h0, 16'h2E18, 1'b1, 16'h0000);
    // Start-up: power-good held off, ramp factor from capacitance
    @(posedge CLK_SYS);
    ON_REQ <= 1'b1;
    VOUT_MV <= 16'h1770;
    wait_en(1'b1, 10);
    cap(16'h0200);
    chk("pg ramp", PG_W, 1'b1);
    chk("rise", RAMP_TIME_US, 16'h4E20);
    drive(16'h2EE0, 16'h03E8, 16'hBB80, 16'h0019);
    settle(5);
    chk("pg on", PG_W, 1'b0);
    acc(1'b0, `C_STAT, 3'h0, 16'h0000, 1'b1, 16'h0800);
    acc(1'b1, `C_POL, 3'h0, 16'h0001, 1'b1, 16'h0000);
    settle(3);
    chk("pg pol", PG_W, 1'b1);
    chk("pg oe", GOOD_OR_SYNC_PIN_OE, 1'b1);
    acc(1'b1, `C_PINS, 3'h0, 16'h0006, 1'b1, 16'h0000);
    settle(3);
    chk("od oe", GOOD_OR_SYNC_PIN_OE, 1'b0);
    acc(1'b1, `C_POL, 3'h0, 16'h0000, 1'b1, 16'h0000);
    settle(3);
    chk("od low", PG_W, 1'b0);
    drive(16'h2C88, 16'h03E8, 16'hBB80, 16'h0019);
    settle(3);
    chk("pg off", PG_W, 1'b1);
    drive(16'h2EE0, 16'h03E8, 16'hBB80, 16'h0019);
    settle(5);
    chk("pg again", PG_W, 1'b0);
    // Sharing trims upward, then clamps
    acc(1'b1, `C_PINS, 3'h0, 16'h0007, 1'b1, 16'h0000);
    tick(5);
    chk("trim", TRIM_MV, 8'h05);
    tick(150);
    chk("trim max", TRIM_MV, `SHARE_MV);
    // Output overvoltage: shut down, restart when clear
    drive(16'h3E80, 16'h03E8, 16'hBB80, 16'h0019);
    settle(3);
    chk("ovp", PWR_EN, 1'b0);
    chk("pg flt", PG_W, 1'b1);
    acc(1'b0, `C_STAT, 3'h0, 16'h0000, 1'b1, 16'h0060);
    drive(16'h0000, 16'h03E8, 16'hBB80, 16'h0019);
    wait_en(1'b1, 1100);
    chk("trim ramp", TRIM_MV, 8'h00);
    cap(16'h0400);
    chk("rise", RAMP_TIME_US, 16'h7530);
    // Overcurrent needs both high current and drooped output
    drive(16'h2EE0, 16'h1F40, 16'hBB80, 16'h0019);
    settle(5);
    chk("oc high v", PWR_EN, 1'b1);
    drive(16'h1B58, 16'h1F40, 16'hBB80, 16'h0019);
    wait_en(1'b0, 10);
    drive(16'h2EE0, 16'h03E8, 16'hBB80, 16'h0019);
    wait_en(1'b1, 1100);
    // Input undervoltage acts only after the response delay
    drive(16'h2EE0, 16'h03E8, 16'h9858, 16'h0019);
    settle(10);
    chk("vin", PWR_EN, 1'b1);
    wait_en(1'b0, 20);
    drive(16'h2EE0, 16'h03E8, 16'hBB80, 16'h0019);
    wait_en(1'b1, 1100);
    // Over-temperature: no restart until below the warning level
    drive(16'h2EE0, 16'h03E8, 16'hBB80, 16'h0082);
    wait_en(1'b0, 10);
    drive(16'h2EE0, 16'h03E8, 16'hBB80, 16'h0078);
    settle(1200);
    chk("ot hold", PWR_EN, 1'b0);
    drive(16'h2EE0, 16'h03E8, 16'hBB80, 16'h0064);
    wait_en(1'b1, 1100);
    // Load levels: two single steps down, then slew at the rate
    acc(1'b1, `C_DBV, 3'h4, 16'h2AF8, 1'b1, 16'h0000);
    acc(1'b1, `C_DBV, 3'h6, 16'h0001, 1'b1, 16'h0000);
    tick(5);
    chk("ref", REF_MV, 16'h2EC2);
    @(posedge CLK_SYS);
    CE <= 1'b0;
    tick(2);
    chk("ce hold", REF_MV, 16'h2EC2);
    @(posedge CLK_SYS);
    CE <= 1'b1;
    // Sync source on the address-1 pin: half period at 250 kHz
    acc(1'b1, `C_PINS, 3'h0, 16'h0028, 1'b1, 16'h0000);
    settle(3);
    chk("a1 oe", ADDR1_OE, 1'b1);
    half_low(16'h01F4);
    // Receiver restarts its period on every sync rising edge
    acc(1'b1, `C_PINS, 3'h0, 16'h0030, 1'b1, 16'h0000);
    settle(20);
    chk("a1 rcv", ADDR1_OE, 1'b0);
    chk("sync rcv", SW_CLK, 1'b1);
    settle(500);
    chk("sync rcv", SW_CLK, 1'b1);
    stop_test();
  end
endmodule
